// ### emc_defs.svh
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH
// ********************************************
// Register map (byte offsets on the AXI4-Lite port)
// ********************************************
`define EMC_ADDR_W 12
`define EMC_OFF_PROT 12'h100
`define EMC_OFF_AREA0 12'h110
`define EMC_AREA_STEP 12'h004
`define EMC_OFF_DIV 12'h120
`define EMC_OFF_MODE 12'h124
`define EMC_OFF_WP 12'h128
`define EMC_OFF_STAT 12'h12c
// ********************************************
// Reset values, write masks, keys
// ********************************************
`define EMC_DIV_RST 3'h4
`define EMC_MODE_RST 32'h00000000
`define EMC_WP_RST 3'h1
`define EMC_AREA_RST 32'h00000000
`define EMC_AREA_WMASK 32'hff0000ff
`define EMC_MODE_WMASK 32'h0000001f
`define EMC_UNLOCK_KEY 32'h000000a5
`define EMC_WIN_NIBBLE 4'h1
`define EMC_SHARED_PINS 27'h7ff0000
`define EMC_LOWER_PINS 16
`define EMC_RESP_OKAY 2'h0
`define EMC_RESP_SLVERR 2'h2
// ********************************************
// Divider codes: period and high phase in clk cycles
// ********************************************
`define EMC_DIV_BY2 3'h0
`define EMC_DIV_BY3 3'h1
`define EMC_DIV_BY4 3'h2
`define EMC_DIV_BY5 3'h3
`define EMC_PER_2 3'h2
`define EMC_PER_3 3'h3
`define EMC_PER_4 3'h4
`define EMC_PER_5 3'h5
`define EMC_PER_6 3'h6
`define EMC_HIGH_1 3'h1
`define EMC_HIGH_2 3'h2
`define EMC_HIGH_3 3'h3
`endif

// ### emc_pkg.sv
package emc_pkg;
  // Area select word: base in the top byte, size mask in the low byte
  typedef struct packed {
    logic [7:0] base;
    logic [15:0] rsvd;
    logic [7:0] size;
  } emc_area_type;

  // Operation mode word
  typedef struct packed {
    logic [26:0] rsvd;
    logic upperForce;
    logic lowerForce;
    logic readEdge;
    logic strobeHold;
    logic clockGate;
  } emc_mode_type;

  typedef enum logic [1:0] {
    WS_IDLE,
    WS_PULSE,
    WS_HOLD,
    WS_DONE
  } emc_ws_state_type;
endpackage

// ### emc_clk_div.sv
`timescale 1ns/100ps
`include "emc_defs.svh"
module emc_clk_div (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] divCode,
  output logic busClkLevel,
  output logic riseTick,
  output logic fallTick
);
  logic [2:0] cnt_q;
  logic [2:0] period;
  logic [2:0] high;
  logic [2:0] cnt_d;
  logic level_d;

  // Ratio table; unlisted codes fall back to the slowest ratio
  always_comb begin
    case (divCode)
      `EMC_DIV_BY2: begin
        period = `EMC_PER_2;
        high = `EMC_HIGH_1;
      end
      `EMC_DIV_BY3: begin
        period = `EMC_PER_3;
        high = `EMC_HIGH_1;
      end
      `EMC_DIV_BY4: begin
        period = `EMC_PER_4;
        high = `EMC_HIGH_2;
      end
      `EMC_DIV_BY5: begin
        period = `EMC_PER_5;
        high = `EMC_HIGH_2;
      end
      default: begin
        period = `EMC_PER_6;
        high = `EMC_HIGH_3;
      end
    endcase
    cnt_d = (cnt_q >= period - 3'h1) ? 3'h0 : cnt_q + 3'h1;
    level_d = cnt_d < high;
  end

  // Phase counter and level; ticks mark the cycle the level changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      busClkLevel <= 1'b0;
      riseTick <= 1'b0;
      fallTick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busClkLevel <= level_d;
      riseTick <= level_d & ~busClkLevel;
      fallTick <= ~level_d & busClkLevel;
    end
  end
endmodule

// ### emc_config.sv
// Behaviour
// - Chip selects only decode addresses inside the 1000_0000h..1FFF_FFFFh window.
// - Area hits when address[31:24] AND size mask equals base.
// - Divider register writes need a prior unlock key; reads are free.
// - Divider code selects divide by 2,3,4,5,6; 6 after reset.
// - Same ratio drives the internal bus clock and the external clock pin.
// - Divider bits 31..4 read zero; software writes zero there.
// - Mode bit 4 forces upper address outputs low.
// - Mode bit 3 forces lower address outputs low.
// - Shared address pins are forced only when in port role.
// - Mode bit 2 picks rising or falling bus clock edge for read capture.
// - Mode bit 1 keeps write strobe asserted while chip select stays active; the code holds it until accValid drops.
// - Mode bit 0 outputs the bus clock only while a chip select is active.
// - Write pulse length is 1 to 7 bus clock cycles.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "emc_defs.svh"
module emc_config (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic accValid,
  input wire logic accWrite,
  input wire logic [31:0] accAddr,
  input wire logic [26:0] pinPortRole,
  input wire logic [31:0] memReadData,
  output logic [3:0] chipSelectN,
  output logic [3:0] writeStrobeN,
  output logic extBusClock,
  output logic busClockTick,
  output logic [10:0] upperAddressOut,
  output logic [15:0] lowerAddressOut,
  output logic [31:0] readData,
  output logic readDataValid
);
  // ********************************************
  // Register bus
  // ********************************************
  logic awReady_q, wReady_q, awHave_q, wHave_q, bValid_q;
  logic arReady_q, rValid_q;
  logic [1:0] bResp_q, rResp_q;
  logic [11:0] awAddr_q, rdAddr_q;
  logic [31:0] wData_q, rData_q, merged;
  logic [3:0] wStrb_q;
  logic wrFire, wrMapped, rdMapped;
  logic [31:0] wrOld, rdVal;
  emc_pkg::emc_area_type areaQ [4];
  emc_pkg::emc_mode_type modeQ;
  logic [2:0] divCode_q, wpCode_q, wpCnt_q;
  logic unlocked_q;
  logic [3:0] csN_q, hitVec, wsSel_q, wsN_q;
  logic divLevel, divRise, divFall, inWindow, anyCs, extClk_q, tick_q;
  emc_pkg::emc_ws_state_type ws_q;

  // Register read-back; the flag tells whether the offset is mapped
  function automatic logic [32:0] regValue(input logic [11:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h0};
    case (a)
      `EMC_OFF_PROT: v = {1'b1, 32'h0};
      `EMC_OFF_DIV: v = {1'b1, 29'h0, divCode_q};
      `EMC_OFF_MODE: v = {1'b1, modeQ};
      `EMC_OFF_WP: v = {1'b1, 29'h0, wpCode_q};
      `EMC_OFF_STAT: v = {1'b1, 24'h0, ~csN_q, 3'h0, unlocked_q};
      default: begin
        v = {1'b0, 32'h0};
        for (int i = 0; i < 4; i++) begin
          if (a == `EMC_OFF_AREA0 + 12'(i) * `EMC_AREA_STEP) begin
            v = {1'b1, areaQ[i]};
          end
        end
      end
    endcase
    return v;
  endfunction

  // Byte-lane merge of write data over the old value
  always_comb begin
    {wrMapped, wrOld} = regValue(awAddr_q);
    {rdMapped, rdVal} = regValue(s_axi_araddr);
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = wStrb_q[b] ? wData_q[b*8 +: 8] : wrOld[b*8 +: 8];
    end
  end

  assign wrFire = awHave_q & wHave_q & ~bValid_q;

  // Address and data are taken independently, in either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_q <= 1'b1;
      awHave_q <= 1'b0;
      awAddr_q <= 12'h0;
    end else if (s_axi_awvalid && awReady_q) begin
      awAddr_q <= s_axi_awaddr;
      awHave_q <= 1'b1;
      awReady_q <= 1'b0;
    end else if (bValid_q && s_axi_bready) begin
      awHave_q <= 1'b0;
      awReady_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wReady_q <= 1'b1;
      wHave_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && wReady_q) begin
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
      wHave_q <= 1'b1;
      wReady_q <= 1'b0;
    end else if (bValid_q && s_axi_bready) begin
      wHave_q <= 1'b0;
      wReady_q <= 1'b1;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q <= `EMC_RESP_OKAY;
    end else if (wrFire) begin
      bValid_q <= 1'b1;
      bResp_q <= wrMapped ? `EMC_RESP_OKAY : `EMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Read channel: one read at a time, answered the cycle after the address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h0;
      rResp_q <= `EMC_RESP_OKAY;
      rdAddr_q <= 12'h0;
    end else if (s_axi_arvalid && arReady_q) begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= rdVal;
      rdAddr_q <= s_axi_araddr;
      rResp_q <= rdMapped ? `EMC_RESP_OKAY : `EMC_RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
      arReady_q <= 1'b1;
    end
  end

  // ********************************************
  // Configuration registers
  // ********************************************
  // Unlock arms exactly one following write; any other write disarms it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_q <= 1'b0;
    end else if (wrFire) begin
      unlocked_q <= (awAddr_q == `EMC_OFF_PROT) && (merged == `EMC_UNLOCK_KEY);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCode_q <= `EMC_DIV_RST;
    end else if (wrFire && awAddr_q == `EMC_OFF_DIV && unlocked_q) begin
      divCode_q <= merged[2:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeQ <= `EMC_MODE_RST;
      wpCode_q <= `EMC_WP_RST;
    end else if (wrFire && awAddr_q == `EMC_OFF_MODE) begin
      modeQ <= merged & `EMC_MODE_WMASK;
    end else if (wrFire && awAddr_q == `EMC_OFF_WP) begin
      wpCode_q <= merged[2:0];
    end
  end

  // One area register and one decoder per chip select
  for (genvar i = 0; i < 4; i++) begin : g_area
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        areaQ[i] <= `EMC_AREA_RST;
      end else if (wrFire && awAddr_q == `EMC_OFF_AREA0 + 12'(i) * `EMC_AREA_STEP) begin
        areaQ[i] <= merged & `EMC_AREA_WMASK;
      end
    end
    assign hitVec[i] = (accAddr[31:24] & areaQ[i].size) == areaQ[i].base;
  end

  // ********************************************
  // Bus clock and chip selects
  // ********************************************
  emc_clk_div u_div (
    .clk(clk),
    .rst_n(rst_n),
    .divCode(divCode_q),
    .busClkLevel(divLevel),
    .riseTick(divRise),
    .fallTick(divFall)
  );

  assign inWindow = accAddr[31:28] == `EMC_WIN_NIBBLE;
  assign anyCs = ~&csN_q;

  // Outside the window no decoder may fire, whatever the area values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csN_q <= 4'hf;
    end else begin
      csN_q <= ~(hitVec & {4{accValid & inWindow}});
    end
  end

  // Pin clock and internal tick share one divider so they never drift
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extClk_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      extClk_q <= divLevel & (~modeQ.clockGate | anyCs);
      tick_q <= divRise;
    end
  end

  // ********************************************
  // Address pins
  // ********************************************
  // Dedicated pins always obey the force; shared ones only in port role
  localparam logic [26:0] SHARED_PINS = `EMC_SHARED_PINS;
  for (genvar p = 0; p < 27; p++) begin : g_pin
    logic force_w, addr_q;
    assign force_w = (p < `EMC_LOWER_PINS ? modeQ.lowerForce : modeQ.upperForce)
                     & (~SHARED_PINS[p] | pinPortRole[p]);
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        addr_q <= 1'b0;
      end else begin
        addr_q <= force_w ? 1'b0 : accAddr[p];
      end
    end
    if (p < `EMC_LOWER_PINS) begin : g_lo
      assign lowerAddressOut[p] = addr_q;
    end else begin : g_hi
      assign upperAddressOut[p - `EMC_LOWER_PINS] = addr_q;
    end
  end

  // ********************************************
  // Write strobe and read capture
  // ********************************************
  // Pulse length counts bus clock rises; hold mode waits for accValid to drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ws_q <= emc_pkg::WS_IDLE;
      wpCnt_q <= 3'h0;
      wsSel_q <= 4'h0;
    end else begin
      case (ws_q)
        emc_pkg::WS_IDLE: begin
          if (accValid && accWrite && inWindow && |hitVec) begin
            ws_q <= emc_pkg::WS_PULSE;
            wpCnt_q <= wpCode_q;
            wsSel_q <= hitVec;
          end
        end
        emc_pkg::WS_PULSE: begin
          if (modeQ.strobeHold) begin
            ws_q <= emc_pkg::WS_HOLD;
          end else if (divRise) begin
            if (wpCnt_q <= 3'h1) begin
              ws_q <= emc_pkg::WS_DONE;
            end else begin
              wpCnt_q <= wpCnt_q - 3'h1;
            end
          end
        end
        emc_pkg::WS_HOLD: begin
          if (!accValid) begin
            ws_q <= emc_pkg::WS_IDLE;
          end
        end
        emc_pkg::WS_DONE: begin
          if (!accValid) begin
            ws_q <= emc_pkg::WS_IDLE;
          end
        end
        default: ws_q <= emc_pkg::WS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wsN_q <= 4'hf;
    end else begin
      wsN_q <= (ws_q == emc_pkg::WS_PULSE || ws_q == emc_pkg::WS_HOLD) ? ~wsSel_q : 4'hf;
    end
  end

  // Read data come from pins: two flops before the edge-selected latch
  logic [31:0] rdSync1_q, rdSync2_q, readData_q;
  logic readDataValid_q, capture;
  assign capture = accValid & ~accWrite & anyCs & (modeQ.readEdge ? divFall : divRise);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdSync1_q <= 32'h0;
      rdSync2_q <= 32'h0;
      readData_q <= 32'h0;
      readDataValid_q <= 1'b0;
    end else begin
      rdSync1_q <= memReadData;
      rdSync2_q <= rdSync1_q;
      readDataValid_q <= capture;
      if (capture) begin
        readData_q <= rdSync2_q;
      end
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign chipSelectN = csN_q;
  assign writeStrobeN = wsN_q;
  assign extBusClock = extClk_q;
  assign busClockTick = tick_q;
  assign readData = readData_q;
  assign readDataValid = readDataValid_q;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence lockedDivWrite;
    wrFire && awAddr_q == `EMC_OFF_DIV && !unlocked_q;
  endsequence
  // Code must stay put for the whole period, or a rewrite shifts the phase
  sequence div2Rise;
    divRise && divCode_q == `EMC_DIV_BY2 ##1 (divCode_q == `EMC_DIV_BY2)[*2];
  endsequence

  cs_window_a: assert property (!inWindow |=> csN_q == 4'hf)
    else $error("chip select outside window");
  cs_decode_a: assert property (accValid && inWindow && hitVec[2] |=> !csN_q[2])
    else $error("area decoder missed a hit");
  div_lock_a: assert property (lockedDivWrite |=> $stable(divCode_q))
    else $error("divider written while locked");
  div_ratio_a: assert property (div2Rise |-> divRise)
    else $error("divide by two period wrong");
  div_rsvd_a: assert property (rValid_q && rdAddr_q == `EMC_OFF_DIV |-> rData_q[31:3] == 29'h0)
    else $error("divider reserved bits nonzero");
  upper_force_a: assert property (modeQ.upperForce |=>
    (upperAddressOut & $past(pinPortRole[26:16])) == 11'h0)
    else $error("upper address not forced low");
  lower_force_a: assert property (modeQ.lowerForce |=> lowerAddressOut == 16'h0)
    else $error("lower address not forced low");
  clk_gate_a: assert property (modeQ.clockGate && csN_q == 4'hf |=> !extClk_q)
    else $error("bus clock out while deselected");
  clk_follow_a: assert property (!modeQ.clockGate |=> extClk_q == $past(divLevel))
    else $error("bus clock pin not following divider");
  strobe_hold_a: assert property (ws_q == emc_pkg::WS_HOLD && accValid |=> ws_q == emc_pkg::WS_HOLD)
    else $error("held write strobe released early");
  read_edge_a: assert property (capture |=> readDataValid_q && readData_q == $past(rdSync2_q))
    else $error("read data not captured");
endmodule

// ### emc_mem_model.sv
`timescale 1ns/100ps
// ****************************************
// External memory stand-in
// ****************************************
module emc_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] chipSelectN,
  input wire logic [15:0] lowerAddressOut,
  output logic [31:0] memReadData
);
  logic [31:0] floatPattern_q;

  // Released bus flips every cycle, so stale data never passes for a good read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      floatPattern_q <= 32'h5a5a5a5a;
    end else begin
      floatPattern_q <= ~floatPattern_q;
    end
  end

  // A selected device answers with a word built from the address it sees
  assign memReadData = (&chipSelectN) ? floatPattern_q : {lowerAddressOut, ~lowerAddressOut};
endmodule

// ### ext_mem_ctl_config_test.sv
`timescale 1ns/100ps
`include "emc_defs.svh"
module ext_mem_ctl_config_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata, memReadData, readData, accAddr;
  logic [3:0] s_axi_wstrb, chipSelectN, writeStrobeN;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic accValid, accWrite, extBusClock, busClockTick, readDataValid;
  logic [26:0] pinPortRole;
  logic [10:0] upperAddressOut;
  logic [15:0] lowerAddressOut;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [7:0] lfsr = 8'h3b;
  logic [31:0] areas [4] = '{32'h130000ff, 32'h180000f8, 32'h100000ff, 32'h120000ff};

  always #4 clk = ~clk;

  emc_config DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .accValid, .accWrite, .accAddr, .pinPortRole, .memReadData, .chipSelectN,
    .writeStrobeN, .extBusClock, .busClockTick, .upperAddressOut, .lowerAddressOut, .readData,
    .readDataValid);

  emc_mem_model mem (.clk, .rst_n, .chipSelectN, .lowerAddressOut, .memReadData);

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bus answers are matched against the oldest expectation noted by the driver
  always @(posedge clk) begin
    if (s_axi_bvalid === 1'b1) chk("bresp", (bq.size() > 0) ? bq.pop_front() : 2'h3, s_axi_bresp);
    if (s_axi_rvalid === 1'b1) begin
      chk("read", (rq.size() > 0) ? rq.pop_front() : '1, {s_axi_rresp, s_axi_rdata});
    end
  end

  // Hang guard: the whole run needs only a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  function automatic logic [7:0] next_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [3:0] cs_exp(input logic [31:0] a);
    cs_exp = 4'hf;
    for (int i = 0; i < 4; i++) begin
      if (a[31:28] == 4'h1 && (a[31:24] & areas[i][7:0]) == areas[i][31:24]) cs_exp[i] = 1'b0;
    end
  endfunction

  // Address and data go out together; bready stays high so no release races
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask

  task automatic acc(input logic v, input logic w, input logic [31:0] a, input int idle);
    accValid <= v;
    accWrite <= w;
    accAddr <= a;
    repeat (idle) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] a;
    logic [26:0] role;
    int n, hi;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, accAddr, pinPortRole} <= '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, accValid, accWrite} <= '0;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    s_axi_wstrb <= 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`EMC_OFF_DIV, 32'h4, `EMC_RESP_OKAY);
    rd(`EMC_OFF_MODE, `EMC_MODE_RST, `EMC_RESP_OKAY);
    rd(12'h0f0, 32'h0, `EMC_RESP_SLVERR);
    wr(`EMC_OFF_DIV, 32'h0, `EMC_RESP_OKAY);
    rd(`EMC_OFF_DIV, 32'h4, `EMC_RESP_OKAY);
    $display("Test reset and lock finished");
    // Divider codes 0 to 4: period of the tick and high time of the pin
    for (int c = 0; c < 5; c++) begin
      wr(`EMC_OFF_PROT, `EMC_UNLOCK_KEY, `EMC_RESP_OKAY);
      wr(`EMC_OFF_DIV, 32'(c), `EMC_RESP_OKAY);
      rd(`EMC_OFF_DIV, c, `EMC_RESP_OKAY);
      n = 0;
      repeat (8) @(posedge clk);
      while (busClockTick !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (busClockTick !== 1'b1 && n < 20);
      chk("period", c + 2, n);
      hi = 0;
      repeat (c + 2) begin
        @(posedge clk);
        if (extBusClock === 1'b1) hi++;
      end
      chk("high time", c / 2 + 1, hi);
    end
    $display("Test divider finished");
    // Areas laid out without overlap, then random accesses under each forcing mode
    for (int i = 0; i < 4; i++) begin
      wr(`EMC_OFF_AREA0 + 12'(4 * i), areas[i], `EMC_RESP_OKAY);
      rd(`EMC_OFF_AREA0 + 12'(4 * i), areas[i], `EMC_RESP_OKAY);
    end
    for (int m = 0; m < 4; m++) begin
      acc(1'b0, 1'b0, 32'h0, 2);
      wr(`EMC_OFF_MODE, m << 3, `EMC_RESP_OKAY);
      repeat (12) begin
        for (int k = 0; k < 4; k++) begin
          lfsr = next_lfsr(lfsr);
          a = {a[23:0], lfsr};
        end
        if (lfsr[1]) a[31:28] = 4'h1;
        role = {a[2:0], a[31:8]};
        pinPortRole <= role;
        acc(1'b1, 1'b0, a, 2);
        chk("chip select", cs_exp(a), chipSelectN);
        chk("upper", m[1] ? a[26:16] & ~role[26:16] : a[26:16], upperAddressOut);
        chk("lower", m[0] ? 16'h0 : a[15:0], lowerAddressOut);
      end
    end
    acc(1'b0, 1'b0, 32'h0, 2);
    $display("Test decode finished");
    // Clock pin masked while nothing is selected
    wr(`EMC_OFF_MODE, 32'h1, `EMC_RESP_OKAY);
    n = 0;
    hi = 0;
    repeat (20) begin
      @(posedge clk);
      if (extBusClock !== 1'b0) n++;
    end
    chk("masked clock", 0, n);
    acc(1'b1, 1'b0, 32'h13000040, 0);
    repeat (20) begin
      @(posedge clk);
      if (extBusClock === 1'b1) hi++;
    end
    chk("selected clock", 1, hi > 0);
    acc(1'b0, 1'b0, 32'h0, 2);
    // Strobe held for as long as the select stays active
    wr(`EMC_OFF_MODE, 32'h2, `EMC_RESP_OKAY);
    acc(1'b1, 1'b1, 32'h13000100, 30);
    chk("held strobe", 4'he, writeStrobeN);
    acc(1'b0, 1'b0, 32'h0, 3);
    chk("strobe release", 4'hf, writeStrobeN);
    // Timed strobe at both ends of the pulse code range, divide by 6
    wr(`EMC_OFF_MODE, 32'h0, `EMC_RESP_OKAY);
    for (int w = 1; w < 8; w += 6) begin
      wr(`EMC_OFF_WP, w, `EMC_RESP_OKAY);
      acc(1'b1, 1'b1, 32'h12000010, 0);
      n = 0;
      repeat (60) begin
        @(posedge clk);
        if (writeStrobeN[3] === 1'b0) n++;
      end
      chk("pulse length", 1, n >= 6 * w - 5 && n <= 6 * w);
      acc(1'b0, 1'b0, 32'h0, 3);
    end
    $display("Test strobe finished");
    // Read capture on each bus clock edge
    for (int e = 0; e < 2; e++) begin
      wr(`EMC_OFF_MODE, e << 2, `EMC_RESP_OKAY);
      acc(1'b1, 1'b0, 32'h1c005a3c, 10);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (readDataValid !== 1'b1 && n < 40);
      chk("read valid", 1'b1, readDataValid);
      chk("read edge", e == 0, busClockTick);
      chk("read data", 32'h5a3ca5c3, readData);
      acc(1'b0, 1'b0, 32'h0, 3);
    end
    $display("Test read capture finished");
    print_verdict();
  end
endmodule
